/* qpdi_map.svh */
`ifndef QPDI_MAP_SVH
`define QPDI_MAP_SVH

// Width of the whole data path in bits.
`define QPDI_DATA_W 64
// Width of one data group served by one strobe pair and one flag.
`define QPDI_GRP_W 16
// Number of data groups.
`define QPDI_GRPS 4
// Transfers placed on the lines within one common bus clock period.
`define QPDI_BEATS 4
// Width of one burst line as handed in by the user (four transfers).
`define QPDI_LINE_W 256
// System clock period in nanoseconds.
`define QPDI_CLK_NS 20
// Common bus clock period in nanoseconds.
`define QPDI_BUS_PERIOD_NS 320
// System clock cycles in one common bus clock period.
`define QPDI_PHASES (`QPDI_BUS_PERIOD_NS / `QPDI_CLK_NS)
// Phase counter value at the end of a bus clock period.
`define QPDI_LAST_PHASE 4'hf
// Cycle within a transfer slot at which the slot's strobe falls.
`define QPDI_FALL_CYC 2'h2
// A group is inverted when more ones than this would go out low.
`define QPDI_INV_LIMIT 5'h08
// Idle electrical level of every pulled-up bus line.
`define QPDI_IDLE_DATA 64'hffffffffffffffff
`define QPDI_IDLE_GRP 4'hf

`endif

/* qpdi_pkg.sv */
package qpdi_pkg;

   `include "qpdi_map.svh"

   // Driving end sequencer states, one-hot.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } tx_state_t;

   // One data group as logical or electrical bits.
   typedef logic [`QPDI_GRP_W-1:0] grp_word_t;

   // Returns one when a group should be sent inverted.
   function automatic logic want_invert(input grp_word_t w);
      logic [4:0] ones;
      ones = 5'h00;
      for (int i = 0; i < `QPDI_GRP_W; i++) begin
         ones = ones + {4'h0, w[i]};
      end
      want_invert = (ones > `QPDI_INV_LIMIT);
   endfunction

   // Turns the electrical level of a group back into true data.
   function automatic grp_word_t restore_group(input grp_word_t lvl, input logic flag_n);
      restore_group = flag_n ? ~lvl : lvl;
   endfunction

endpackage

/* qpdi_bus_if.sv */
`timescale 1ns/100ps
`include "qpdi_map.svh"
interface qpdi_bus_if;

   // Common bus clock, made by the driving end.
   logic                   busClk;
   // Driven levels and enables from the driving end.
   logic [`QPDI_DATA_W-1:0] dataOut_n;
   logic                   dataOe;
   logic [`QPDI_GRPS-1:0]   flagOut_n;
   logic [`QPDI_GRPS-1:0]   strbPosOut_n;
   logic [`QPDI_GRPS-1:0]   strbNegOut_n;
   logic                   validOut_n;
   logic                   validOe;
   // Resolved wire levels; an undriven line floats high on its pull-up.
   logic [`QPDI_DATA_W-1:0] dataLine_n;
   logic [`QPDI_GRPS-1:0]   groupInvertFlag_n;
   logic [`QPDI_GRPS-1:0]   dataStrobePos_n;
   logic [`QPDI_GRPS-1:0]   dataStrobeNeg_n;
   logic                   dataValidInd_n;

   assign dataLine_n        = dataOe ? dataOut_n : `QPDI_IDLE_DATA;
   assign groupInvertFlag_n = dataOe ? flagOut_n : `QPDI_IDLE_GRP;
   assign dataStrobePos_n   = dataOe ? strbPosOut_n : `QPDI_IDLE_GRP;
   assign dataStrobeNeg_n   = dataOe ? strbNegOut_n : `QPDI_IDLE_GRP;
   assign dataValidInd_n    = validOe ? validOut_n : 1'b1;

   modport drive_end (
      output busClk, dataOut_n, dataOe, flagOut_n, strbPosOut_n,
             strbNegOut_n, validOut_n, validOe
   );

   modport capture_end (
      input busClk, dataLine_n, groupInvertFlag_n, dataStrobePos_n,
            dataStrobeNeg_n, dataValidInd_n
   );

endinterface

/* qpdi_drive_end.sv */
// Summary of operation
// R1: Data path is 64 bits, shared lines.
// R2: Driver asserts low valid per transfer.
// R3: Four transfers within one bus clock.
// R4: Receiver captures on both strobes' falling edges.
// R5: Each 16-bit group has own strobe pair.
// R6: Group n covers bits 16n to 16n+15.
// R7: One inversion flag per group, from driver.
// R8: Asserted flag means group data inverted.
// R9: Invert when over half would drive low.
// R10: Receiver re-inverts groups with flag asserted.
// R11: Flag decided per transfer, timed with strobes.
`timescale 1ns/100ps
`include "qpdi_map.svh"
module qpdi_drive_end (
   input  wire logic                    clk_sys,
   input  wire logic                    reset,
   qpdi_bus_if.drive_end                bus,
   input  wire logic [`QPDI_LINE_W-1:0] lineData,
   input  wire logic                    lineValid,
   output      logic                    lineReady,
   input  wire logic                    invertEnable,
   output      logic                    busy
);

   // Free running position within the common bus clock period.
   logic [3:0]                 phase_ff;
   logic [3:0]                 nxt_phase;
   // Sequencer state.
   qpdi_pkg::tx_state_t        state_ff;
   qpdi_pkg::tx_state_t        nxt_state;
   // Line accepted from the user and waiting for the next period.
   logic                       pending_ff;
   logic                       nxt_pending;
   logic [`QPDI_LINE_W-1:0]    holdLine_ff;
   // Line currently being placed on the bus.
   logic [`QPDI_LINE_W-1:0]    sendLine_ff;
   // Registered pin levels and enables.
   logic [`QPDI_DATA_W-1:0]    dataOut_ff;
   logic [`QPDI_DATA_W-1:0]    nxt_dataOut;
   logic [`QPDI_GRPS-1:0]      flagOut_ff;
   logic [`QPDI_GRPS-1:0]      nxt_flagOut;
   logic [`QPDI_GRPS-1:0]      strbPos_ff;
   logic [`QPDI_GRPS-1:0]      strbNeg_ff;
   logic                       valid_ff;
   logic                       oe_ff;
   logic                       busClk_ff;

   // Handshake and sequencing terms.
   wire                        take;
   wire                        lastPhase;
   wire                        launch;
   wire                        sending;
   // Transfer slot within the period and cycle within the slot.
   wire [1:0]                  beat;
   wire [1:0]                  slotCyc;
   // True data of the current transfer.
   wire [`QPDI_DATA_W-1:0]     beatWord;
   // Strobe of the current slot is low from mid slot onward.
   wire                        strobeLow;

   // The user may hand in a new line whenever nothing is waiting.
   assign lineReady = ~pending_ff;
   assign take      = lineValid & lineReady;
   assign lastPhase = (phase_ff == `QPDI_LAST_PHASE);
   // A waiting line starts at the next bus clock period boundary.
   assign launch    = pending_ff & lastPhase;
   assign sending   = (state_ff == qpdi_pkg::ST_SEND);
   assign busy      = sending;
   assign nxt_phase = 4'(phase_ff + 4'h1);

   // Four slots per bus clock period, one per transfer.
   assign beat      = phase_ff[3:2]; // R3
   assign slotCyc   = phase_ff[1:0];
   assign beatWord  = sendLine_ff[{beat, 6'h00} +: `QPDI_DATA_W]; // R1
   assign strobeLow = sending & (slotCyc >= `QPDI_FALL_CYC);

   // Pending flag is set by a take and cleared by a launch; both never coincide.
   assign nxt_pending = take ? 1'b1 : (launch ? 1'b0 : pending_ff);

   // Sequencer: idle until a line launches, stay busy while lines follow back to back.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         qpdi_pkg::ST_IDLE: begin
            // Begin a burst at the period boundary.
            if (launch) begin
               nxt_state = qpdi_pkg::ST_SEND;
            end
         end
         qpdi_pkg::ST_SEND: begin
            // End the burst after the fourth slot unless another line waits.
            if (lastPhase && !pending_ff) begin
               nxt_state = qpdi_pkg::ST_IDLE;
            end
         end
         default: begin
            // Recover from an illegal code.
            nxt_state = qpdi_pkg::ST_IDLE;
         end
      endcase
   end

   // Per group encoding of the current transfer.
   generate
      for (genvar g = 0; g < `QPDI_GRPS; g++) begin : g_grp
         // Bits 16g to 16g+15 belong to group g.
         wire [`QPDI_GRP_W-1:0] grpTrue = beatWord[g*`QPDI_GRP_W +: `QPDI_GRP_W]; // R6
         // Inversion is decided afresh for every transfer and only when allowed.
         wire invNow = invertEnable & qpdi_pkg::want_invert(grpTrue); // R9 R11
         // Logical data sent; a logical one goes out electrically low.
         wire [`QPDI_GRP_W-1:0] grpSent = invNow ? ~grpTrue : grpTrue; // R8
         assign nxt_dataOut[g*`QPDI_GRP_W +: `QPDI_GRP_W] = sending ? ~grpSent
                                                                    : {`QPDI_GRP_W{1'b1}};
         // One active low flag per group, driven with its group's data.
         assign nxt_flagOut[g] = ~(sending & invNow); // R7
      end
   endgenerate

   // Phase counter runs freely and paces the common bus clock.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         // Start every period count from slot zero.
         phase_ff <= 4'h0;
      end else begin
         // The count wraps from fifteen to zero on its own.
         phase_ff <= nxt_phase;
      end
   end

   // State and waiting-line bookkeeping.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         // Nothing waits and nothing is sent after reset.
         state_ff   <= qpdi_pkg::ST_IDLE;
         pending_ff <= 1'b0;
      end else begin
         // Move on and track whether a line waits.
         state_ff   <= nxt_state;
         pending_ff <= nxt_pending;
      end
   end

   // Line capture: hold on take, move to the send register on launch.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         // Cleared lines keep the encoder inputs at a known value.
         holdLine_ff <= '0;
         sendLine_ff <= '0;
      end else begin
         // A new line waits in the hold register.
         if (take) begin
            holdLine_ff <= lineData;
         end
         // The waiting line moves on at the period boundary.
         if (launch) begin
            sendLine_ff <= holdLine_ff;
         end
      end
   end

   // Data and flag pins, registered so every group changes on one edge.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         // Released lines idle at the pull-up level.
         dataOut_ff <= `QPDI_IDLE_DATA;
         flagOut_ff <= `QPDI_IDLE_GRP;
      end else begin
         // Pins follow the encoding of the current slot.
         dataOut_ff <= nxt_dataOut; // R1
         flagOut_ff <= nxt_flagOut; // R8
      end
   end

   // Strobes: the positive strobe falls in even slots, the negative in odd ones.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         // Both strobes rest high between bursts.
         strbPos_ff <= `QPDI_IDLE_GRP;
         strbNeg_ff <= `QPDI_IDLE_GRP;
      end else begin
         // Only the strobe of the current slot may be low.
         strbPos_ff <= {`QPDI_GRPS{~(strobeLow & ~beat[0])}}; // R4 R5
         strbNeg_ff <= {`QPDI_GRPS{~(strobeLow & beat[0])}}; // R4 R5
      end
   end

   // Valid indication, output enable and the common bus clock.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         // The bus is released and its clock starts low.
         valid_ff  <= 1'b1;
         oe_ff     <= 1'b0;
         busClk_ff <= 1'b0;
      end else begin
         valid_ff  <= ~sending; // R2
         oe_ff     <= sending;
         busClk_ff <= ~phase_ff[3]; // R3
      end
   end

   // Pin drive; the lines float high whenever the enable is low.
   // Both enables come from oe_ff and valid from valid_ff, loaded from the same term, so they move together.
   assign bus.busClk       = busClk_ff;
   assign bus.dataOut_n    = dataOut_ff;
   assign bus.dataOe       = oe_ff;
   assign bus.flagOut_n    = flagOut_ff;
   assign bus.strbPosOut_n = strbPos_ff;
   assign bus.strbNegOut_n = strbNeg_ff;
   assign bus.validOut_n   = valid_ff;
   assign bus.validOe      = oe_ff;

endmodule

/* qpdi_capture_end.sv */
`timescale 1ns/100ps
`include "qpdi_map.svh"
module qpdi_capture_end (
   input  wire logic                     clk_sys,
   input  wire logic                     reset,
   qpdi_bus_if.capture_end               bus,
   output      logic [`QPDI_DATA_W-1:0]  wordData,
   output      logic [1:0]               wordBeat,
   output      logic                     wordValid
);

   // Width of the packed pin bundle: clock, valid, strobes, flags, data.
   localparam int IN_W = `QPDI_DATA_W + 3*`QPDI_GRPS + 2;

   // Two flip-flop synchroniser and a history stage for edge finding.
   logic [IN_W-1:0]            meta_ff;
   logic [IN_W-1:0]            sync_ff;
   logic [`QPDI_GRPS*2:0]      prev_ff;
   // Captured true data per group, its slot and whether it is fresh.
   logic [`QPDI_DATA_W-1:0]    grpWord_ff;
   logic [`QPDI_GRPS*2-1:0]    beatCnt_ff;
   logic [1:0]                 grpBeat_ff [`QPDI_GRPS];
   logic [`QPDI_GRPS-1:0]      have_ff;
   // Output registers.
   logic [`QPDI_DATA_W-1:0]    wordData_ff;
   logic [1:0]                 wordBeat_ff;
   logic                       wordValid_ff;

   // Raw pins and their synchronised views.
   wire [IN_W-1:0]             rawIn;
   wire [`QPDI_DATA_W-1:0]     sData;
   wire [`QPDI_GRPS-1:0]       sFlag;
   wire [`QPDI_GRPS-1:0]       sPos;
   wire [`QPDI_GRPS-1:0]       sNeg;
   wire                        sValid;
   wire                        sClk;
   // Edge terms and the emit decision.
   wire [`QPDI_GRPS-1:0]       capEn;
   wire                        clkRise;
   wire                        emit;

   assign rawIn  = {bus.busClk, bus.dataValidInd_n, bus.dataStrobeNeg_n,
                    bus.dataStrobePos_n, bus.groupInvertFlag_n, bus.dataLine_n};
   assign sData  = sync_ff[`QPDI_DATA_W-1:0];
   assign sFlag  = sync_ff[`QPDI_DATA_W +: `QPDI_GRPS];
   assign sPos   = sync_ff[`QPDI_DATA_W+`QPDI_GRPS +: `QPDI_GRPS];
   assign sNeg   = sync_ff[`QPDI_DATA_W+2*`QPDI_GRPS +: `QPDI_GRPS];
   assign sValid = sync_ff[IN_W-2];
   assign sClk   = sync_ff[IN_W-1];
   // A rising common clock marks the start of a new set of four slots.
   assign clkRise = sClk & ~prev_ff[`QPDI_GRPS*2];
   // A word leaves once every group has delivered its part.
   assign emit    = &have_ff;

   // Synchroniser; the first stage feeds only the second.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         meta_ff <= '1;
         sync_ff <= '1;
         // History matches the reset synchroniser, so no false edge follows reset.
         prev_ff <= '1;
      end else begin
         meta_ff <= rawIn;
         sync_ff <= meta_ff;
         prev_ff <= {sClk, sNeg, sPos};
      end
   end

   // Per group capture on the falling edge of either strobe of that group.
   generate
      for (genvar g = 0; g < `QPDI_GRPS; g++) begin : g_grp
         // Strobe pair g serves bits 16g to 16g+15 only.
         wire fall = (prev_ff[g] & ~sPos[g]) | // R4 R5 R6
                     (prev_ff[`QPDI_GRPS+g] & ~sNeg[g]); // R4 R5 R6
         assign capEn[g] = fall & ~sValid; // R2
         wire [1:0] cnt = beatCnt_ff[2*g +: 2];
         // Count slots, record the captured word, mark it fresh; set beats clear.
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               beatCnt_ff[2*g +: 2]               <= 2'h0;
               grpBeat_ff[g]                       <= 2'h0;
               grpWord_ff[g*`QPDI_GRP_W +: `QPDI_GRP_W] <= '0;
               have_ff[g]                          <= 1'b0;
            end else begin
               if (clkRise) begin
                  beatCnt_ff[2*g +: 2] <= 2'h0;
               end else if (capEn[g]) begin
                  beatCnt_ff[2*g +: 2] <= 2'(cnt + 2'h1);
               end
               if (capEn[g]) begin
                  grpBeat_ff[g] <= clkRise ? 2'h0 : cnt;
                  // The flag sampled with this transfer decides re-inversion.
                  grpWord_ff[g*`QPDI_GRP_W +: `QPDI_GRP_W] <= // R10
                     qpdi_pkg::restore_group(sData[g*`QPDI_GRP_W +: `QPDI_GRP_W], sFlag[g]);
               end
               have_ff[g] <= capEn[g] | (have_ff[g] & ~emit);
            end
         end
      end
   endgenerate

   // Output word, its slot number and a one-cycle valid pulse.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wordData_ff  <= '0;
         wordBeat_ff  <= 2'h0;
         wordValid_ff <= 1'b0;
      end else begin
         wordValid_ff <= emit;
         if (emit) begin
            wordData_ff <= grpWord_ff;
            wordBeat_ff <= grpBeat_ff[0];
         end
      end
   end

   assign wordData  = wordData_ff;
   assign wordBeat  = wordBeat_ff;
   assign wordValid = wordValid_ff;

endmodule

/* quad_pumped_data_inversion_monitor.sv */
`timescale 1ns/100ps
module qpdi_link_monitor (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        busClk,
   input wire logic [63:0] dataLine_n,
   input wire logic [3:0]  groupInvertFlag_n,
   input wire logic [3:0]  dataStrobePos_n,
   input wire logic [3:0]  dataStrobeNeg_n,
   input wire logic        dataValidInd_n
);
   // Every property samples on the system clock and rests during reset.
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Group zero strobes serve as the timing reference for all groups.
   wire strbP = dataStrobePos_n[0];
   wire strbN = dataStrobeNeg_n[0];
   // The common bus clock is high for half of its sixteen cycle period.
   property p_bus_clk;
      $rose(busClk) |-> busClk[*8] ##1 !busClk;
   endproperty
   a_bus_clk: assert property (p_bus_clk) else $error("bus clock high time wrong");
   // A burst starts together with a rising bus clock.
   property p_burst_start;
      $fell(dataValidInd_n) |-> $rose(busClk);
   endproperty
   a_burst_start: assert property (p_burst_start) else $error("burst off bus clock");
   // Four strobe falls, alternating pos and neg, come in one bus period.
   property p_four_beats;
      $fell(dataValidInd_n) |-> ##2 $fell(strbP) ##4 $fell(strbN) ##4 $fell(strbP)
         ##4 $fell(strbN);
   endproperty
   a_four_beats: assert property (p_four_beats) else $error("beat strobes misplaced");
   // A strobe only falls while the valid indication is asserted.
   property p_strb_valid;
      ($fell(strbP) || $fell(strbN)) |-> !dataValidInd_n;
   endproperty
   a_strb_valid: assert property (p_strb_valid) else $error("strobe without valid");
   // Every group has its own strobe pair, all moving together.
   property p_grp_strb;
      dataStrobePos_n == {4{strbP}} && dataStrobeNeg_n == {4{strbN}};
   endproperty
   a_grp_strb: assert property (p_grp_strb) else $error("group strobes differ");
   // The two phases never capture at once.
   property p_one_strb;
      !(!strbP && !strbN);
   endproperty
   a_one_strb: assert property (p_one_strb) else $error("both strobes low");
   // Data and flags hold still around each capturing strobe fall.
   property p_stable;
      ($fell(strbP) || $fell(strbN)) |-> $stable(dataLine_n) && $stable(groupInvertFlag_n)
         ##1 $stable(dataLine_n) && $stable(groupInvertFlag_n);
   endproperty
   a_stable: assert property (p_stable) else $error("data moved at strobe");
   // An asserted flag on group zero or three only appears on a group that would mostly go low.
   property p_flag;
      !dataValidInd_n |-> (groupInvertFlag_n[0] || $countones(dataLine_n[15:0]) > 8)
         && (groupInvertFlag_n[3] || $countones(dataLine_n[63:48]) > 8);
   endproperty
   a_flag: assert property (p_flag) else $error("inversion flag unjustified");
endmodule

/* quad_pumped_data_inversion_test.sv */
`timescale 1ns/100ps
module quad_pumped_data_inversion_test;
   logic         clk_sys, reset, lineValid, invertEnable, prevP, prevN;
   logic [255:0] lineData;
   wire          lineReady, busy, wordValid, wordValidB;
   wire  [63:0]  wordData, wordDataB;
   wire  [1:0]   wordBeat;
   int           nMismatch, checksDone, nB, nBusy;
   logic [63:0]  gotData[$];
   logic [1:0]   gotBeat[$];
   logic [67:0]  gotWire[$];
   // Lines with group values around the inversion threshold.
   logic [255:0] lineA = {64'hfedc_ba98_7654_3210, 64'h0000_ffff_01ff_00ff,
                          64'h8001_7ffe_0f0f_ffff, 64'h0123_4567_89ab_cdef};
   logic [255:0] lineB = {64'h01ff_00ff_ffff_0000, 64'h7fff_8000_fffe_0001,
                          64'haaaa_5555_ff00_03ff, 64'h0000_0000_ffff_ffff};
   qpdi_bus_if link ();
   qpdi_bus_if badLink ();
   qpdi_drive_end qpdi_drive_end_inst (.clk_sys(clk_sys), .reset(reset), .bus(link),
      .lineData(lineData), .lineValid(lineValid), .lineReady(lineReady),
      .invertEnable(invertEnable), .busy(busy));
   qpdi_capture_end qpdi_capture_end_inst (.clk_sys(clk_sys), .reset(reset), .bus(link),
      .wordData(wordData), .wordBeat(wordBeat), .wordValid(wordValid));
   // Second receiver faces a bench driver that can break the link rules.
   qpdi_capture_end qpdi_capture_end_inst_b (.clk_sys(clk_sys), .reset(reset),
      .bus(badLink), .wordData(wordDataB), .wordBeat(), .wordValid(wordValidB));
   qpdi_link_monitor qpdi_link_monitor_inst (.clk_sys(clk_sys), .reset(reset),
      .busClk(link.busClk), .dataLine_n(link.dataLine_n),
      .groupInvertFlag_n(link.groupInvertFlag_n), .dataStrobePos_n(link.dataStrobePos_n),
      .dataStrobeNeg_n(link.dataStrobeNeg_n), .dataValidInd_n(link.dataValidInd_n));
   // The system clock runs at 50 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // Collects restored words and the wire levels seen at each strobe fall.
   always @(posedge clk_sys) begin
      if (wordValid) begin
         gotData.push_back(wordData);
         gotBeat.push_back(wordBeat);
      end
      if ((prevP && !link.dataStrobePos_n[0]) || (prevN && !link.dataStrobeNeg_n[0]))
         gotWire.push_back({link.groupInvertFlag_n, link.dataLine_n});
      if (wordValidB) nB++;
      if (busy) nBusy++;
      prevP <= link.dataStrobePos_n[0];
      prevN <= link.dataStrobeNeg_n[0];
   end
   // Compares one value and counts the outcome.
   task automatic check(input string what, input logic [67:0] seen, input logic [67:0] exp);
      checksDone++;
      if (seen !== exp) begin
         nMismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Expected flags and electrical levels of one transfer.
   function automatic logic [67:0] wire_of(input logic [63:0] d, input logic inv);
      logic [3:0]  f;
      logic [63:0] l;
      for (int g = 0; g < 4; g++) begin
         f[g] = !(inv && $countones(d[16*g +: 16]) > 8);
         l[16*g +: 16] = f[g] ? ~d[16*g +: 16] : d[16*g +: 16];
      end
      return {f, l};
   endfunction
   // Offers lines back to back and judges every transfer that comes out.
   task automatic run_lines(input string name, input logic [255:0] lines[$], input logic inv);
      int n;
      logic [63:0] d;
      gotData.delete();
      gotBeat.delete();
      gotWire.delete();
      nBusy = 0;
      @(negedge clk_sys);
      invertEnable = inv;
      lineValid = 1'b1;
      foreach (lines[i]) begin
         lineData = lines[i];
         n = 0;
         while (lineReady !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
         end
         @(negedge clk_sys);
      end
      lineValid = 1'b0;
      n = 0;
      while (gotData.size() < 4 * lines.size() && n < 400) begin
         @(posedge clk_sys);
         n++;
      end
      check("word count", gotData.size(), 4 * lines.size());
      for (int k = 0; k < gotData.size(); k++) begin
         d = lines[k / 4][64 * (k % 4) +: 64];
         check("word", gotData[k], d);
         check("beat", gotBeat[k], k % 4);
         check("wire", gotWire[k], wire_of(d, inv));
      end
      check("busy", busy, 1'b0);
      check("busy cycles", nBusy, 16 * lines.size());
      $display("Test %s done", name);
   endtask
   task automatic test_plain();
      run_lines("plain", '{lineA}, 1'b0);
   endtask
   task automatic test_invert();
      run_lines("invert", '{lineA, lineB, lineA}, 1'b1);
   endtask
   // One bench-made transfer with a pos strobe fall; valid chooses legality.
   task automatic pulse(input logic val);
      @(negedge clk_sys);
      badLink.busClk = 1'b1;
      badLink.dataOe = 1'b1;
      badLink.validOe = val;
      badLink.dataOut_n = ~64'h1234_5678_9abc_def0;
      repeat (2) @(negedge clk_sys);
      badLink.strbPosOut_n = 4'h0;
      repeat (2) @(negedge clk_sys);
      badLink.busClk = 1'b0;
      badLink.strbPosOut_n = 4'hf;
      repeat (2) @(negedge clk_sys);
      badLink.dataOe = 1'b0;
      badLink.validOe = 1'b0;
      repeat (8) @(negedge clk_sys);
   endtask
   task automatic test_refused();
      nB = 0;
      pulse(1'b0);
      check("ignored strobe", nB, 0);
      pulse(1'b1);
      check("legal strobe", nB, 1);
      check("legal word", wordDataB, 64'h1234_5678_9abc_def0);
      $display("Test refused done");
   endtask
   task automatic print_verdict();
      $display("Checks %0d mismatches %0d", checksDone, nMismatch);
      if (nMismatch == 0 && checksDone > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Watchdog cuts a hang well beyond the expected run time.
   initial begin
      #100000;
      nMismatch++;
      print_verdict();
   end
   // Main sequence: reset for ten cycles, then every test in turn.
   initial begin
      reset = 1'b1;
      lineData = '0;
      lineValid = 1'b0;
      invertEnable = 1'b0;
      badLink.busClk = 1'b0;
      badLink.dataOe = 1'b0;
      badLink.validOe = 1'b0;
      badLink.validOut_n = 1'b0;
      badLink.dataOut_n = '1;
      badLink.flagOut_n = 4'hf;
      badLink.strbPosOut_n = 4'hf;
      badLink.strbNegOut_n = 4'hf;
      repeat (10) @(negedge clk_sys);
      reset = 1'b0;
      test_plain();
      test_invert();
      test_refused();
      print_verdict();
   end
endmodule
